// file: leoc_pkg.sv
// constants, carrier types and decode helpers for the lamp config registers
package leoc_pkg;

  // ----------------------------------------------------------------------
  // register addresses and masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] LEOC_EMI_ADDR = 8'hf6; // interference control
  localparam logic [7:0] LEOC_OVR_ADDR = 8'hf7; // current overdrive control
  localparam logic [7:0] LEOC_EMI_RESET = 8'h00; // defined bits clear
  localparam logic [7:0] LEOC_OVR_RESET = 8'h00; // all bits clear
  localparam logic [7:0] LEOC_EMI_WMASK = 8'hf7; // bit 3 held at zero
  localparam logic [7:0] LEOC_OVR_WMASK = 8'hff; // every bit writable
  localparam logic [7:0] LEOC_UNMAPPED = 8'h00; // read of other address

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int LEOC_SPREAD_LSB = 0; // spread select, 2 bits
  localparam int LEOC_SHAPE_BIT = 2; // spread shape select
  localparam int LEOC_STEP_EN_BIT = 4; // frequency step enable
  localparam int LEOC_STEP_SEL_LSB = 5; // step select, 3 bits
  localparam int LEOC_STEP_DIR_BIT = 7; // step select msb: down
  localparam int LEOC_LEVEL_LSB = 0; // overdrive level, 3 bits
  localparam int LEOC_OVR_EN_BIT = 3; // overdrive enable
  localparam int LEOC_TIMEOUT_LSB = 4; // timeout field, 4 bits

  // ----------------------------------------------------------------------
  // spread amounts in tenths of a percent
  // ----------------------------------------------------------------------
  localparam logic [6:0] LEOC_SPREAD_OFF = 7'h00; // no spreading
  localparam logic [6:0] LEOC_SPREAD_1P5 = 7'h0f; // 1.5 %
  localparam logic [6:0] LEOC_SPREAD_3P0 = 7'h1e; // 3.0 %
  localparam logic [6:0] LEOC_SPREAD_6P0 = 7'h3c; // 6.0 %

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  // register access from the serial management logic
  typedef struct packed {
    logic [7:0] addr; // register address
    logic [7:0] wdata; // write data
    logic wr; // write strobe, one cycle
    logic rd; // read strobe, one cycle
  } leoc_req_s;

  // shadow load from nonvolatile memory
  typedef struct packed {
    logic load; // one-cycle load strobe
    logic [7:0] emi; // stored interference byte
    logic [7:0] ovr; // stored overdrive byte
  } leoc_nv_s;

  // settings handed to the oscillator and current loop
  typedef struct packed {
    logic [6:0] spread_x10; // spread, tenths of a percent
    logic spread_random; // 1 random, 0 triangular
    logic step_active; // frequency step applied
    logic step_down; // 1 step down, 0 step up
    logic [2:0] step_pct; // step size 1 to 4 percent
    logic ovr_active; // overdrive current applied
    logic [3:0] ovr_eighths; // extra current in eighths
    logic [3:0] ovr_timeout; // raw timeout code
  } leoc_ctrl_s;

  // whole state of the block
  typedef struct packed {
    logic [7:0] emi_r; // interference control
    logic [7:0] ovr_r; // overdrive control
    logic [1:0] step_pin_sync; // step pin synchroniser
    logic [1:0] ovr_pin_sync; // overdrive pin synchroniser
    logic [7:0] rdata_r; // read answer
    leoc_ctrl_s ctrl_r; // registered settings
  } leoc_state_s;

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // spread code to amount
  function automatic logic [6:0] leoc_spread_x10(input logic [1:0] code);
    case (code)
      2'h1: leoc_spread_x10 = LEOC_SPREAD_1P5;
      2'h2: leoc_spread_x10 = LEOC_SPREAD_3P0;
      2'h3: leoc_spread_x10 = LEOC_SPREAD_6P0;
      default: leoc_spread_x10 = LEOC_SPREAD_OFF;
    endcase
  endfunction : leoc_spread_x10

endpackage : leoc_pkg

// file: leoc_regs.sv
// interference and overdrive configuration registers of the lamp controller
`timescale 1ns/1ps

module leoc_regs
  import leoc_pkg::*;
(
  // clock and reset (reset also stands for power-down)
  input wire logic CLK,
  input wire logic RST,
  // register access
  input wire leoc_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  // nonvolatile shadow load
  input wire leoc_nv_s NV,
  // asynchronous pins
  input wire logic STEP_PIN,
  input wire logic OVR_PIN,
  // settings to the lamp logic
  output leoc_ctrl_s CTRL
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  leoc_state_s state_r; // registered state
  leoc_state_s state_nxt; // next state
  logic emi_hit; // address decodes to F6h
  logic ovr_hit; // address decodes to F7h

  assign emi_hit = (REG_REQ.addr == LEOC_EMI_ADDR);
  assign ovr_hit = (REG_REQ.addr == LEOC_OVR_ADDR);

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  // shadow load first, then a software write in the same cycle wins
  always_comb begin
    state_nxt = state_r;
    // pins pass two flops; first flop feeds only the second
    state_nxt.step_pin_sync = {state_r.step_pin_sync[0], STEP_PIN};
    state_nxt.ovr_pin_sync = {state_r.ovr_pin_sync[0], OVR_PIN};
    // copy from nonvolatile memory
    if (NV.load) begin
      state_nxt.emi_r = NV.emi & LEOC_EMI_WMASK;
      state_nxt.ovr_r = NV.ovr & LEOC_OVR_WMASK;
    end
    // software writes; reserved bit 3 never stored
    if (REG_REQ.wr && emi_hit) begin
      state_nxt.emi_r = REG_REQ.wdata & LEOC_EMI_WMASK;
    end
    if (REG_REQ.wr && ovr_hit) begin
      state_nxt.ovr_r = REG_REQ.wdata & LEOC_OVR_WMASK;
    end
    // read answer, zero for unmapped addresses
    if (REG_REQ.rd) begin
      if (emi_hit) begin
        state_nxt.rdata_r = state_r.emi_r;
      end else if (ovr_hit) begin
        state_nxt.rdata_r = state_r.ovr_r;
      end else begin
        state_nxt.rdata_r = LEOC_UNMAPPED;
      end
    end
    // settings from the current registers and synced pins
    state_nxt.ctrl_r.spread_x10 =
      leoc_spread_x10(state_r.emi_r[LEOC_SPREAD_LSB +: 2]);
    state_nxt.ctrl_r.spread_random = state_r.emi_r[LEOC_SHAPE_BIT];
    state_nxt.ctrl_r.step_active =
      state_r.emi_r[LEOC_STEP_EN_BIT] | state_r.step_pin_sync[1];
    state_nxt.ctrl_r.step_down = state_r.emi_r[LEOC_STEP_DIR_BIT];
    state_nxt.ctrl_r.step_pct =
      {1'b0, state_r.emi_r[LEOC_STEP_SEL_LSB +: 2]} + 3'h1;
    state_nxt.ctrl_r.ovr_active =
      state_r.ovr_r[LEOC_OVR_EN_BIT] | state_r.ovr_pin_sync[1];
    state_nxt.ctrl_r.ovr_eighths =
      {1'b0, state_r.ovr_r[LEOC_LEVEL_LSB +: 3]} + 4'h1;
    state_nxt.ctrl_r.ovr_timeout = state_r.ovr_r[LEOC_TIMEOUT_LSB +: 4];
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // reset and power-down clear everything
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= '0;
      state_r.emi_r <= LEOC_EMI_RESET;
      state_r.ovr_r <= LEOC_OVR_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from flops
  assign REG_RDATA = state_r.rdata_r;
  assign CTRL = state_r.ctrl_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // helper copies for past values
  logic [7:0] chk_emi; // interference register
  logic [7:0] chk_ovr; // overdrive register
  logic chk_step_pin; // synced step pin
  logic chk_ovr_pin; // synced overdrive pin
  assign chk_emi = state_r.emi_r;
  assign chk_ovr = state_r.ovr_r;
  assign chk_step_pin = state_r.step_pin_sync[1];
  assign chk_ovr_pin = state_r.ovr_pin_sync[1];

  // write to F6h lands one cycle later, bit 3 clear
  AST_EMI_WRITE: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.wr && emi_hit) |=> (chk_emi == ($past(REG_REQ.wdata) & 8'hf7)))
    else $error("interference write not stored");

  // spread amount follows the code two cycles after the write
  AST_SPREAD: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.wr && emi_hit) |-> ##2
      (CTRL.spread_x10 == leoc_spread_x10($past(REG_REQ.wdata[1:0], 2))))
    else $error("spread amount wrong");

  // step applied exactly when enable bit or pin is set
  AST_STEP_OR: assert property (@(posedge CLK) disable iff (RST)
    ##1 (CTRL.step_active == ($past(chk_emi[4]) || $past(chk_step_pin))))
    else $error("step enable not ORed with pin");

  // write to F7h lands one cycle later in full
  AST_OVR_WRITE: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.wr && ovr_hit) |=> (chk_ovr == $past(REG_REQ.wdata)))
    else $error("overdrive write not stored");

  // extra current is code plus one eighths
  AST_OVR_LEVEL: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.wr && ovr_hit) |-> ##2
      (CTRL.ovr_eighths == {1'b0, $past(REG_REQ.wdata[2:0], 2)} + 4'h1))
    else $error("overdrive level wrong");

  // overdrive applied exactly when enable bit or pin is set
  AST_OVR_OR: assert property (@(posedge CLK) disable iff (RST)
    ##1 (CTRL.ovr_active == ($past(chk_ovr[3]) || $past(chk_ovr_pin))))
    else $error("overdrive enable not ORed with pin");

  // step direction and size follow bits 7:5
  AST_STEP_SEL: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.wr && emi_hit) |-> ##2
      ((CTRL.step_down == $past(REG_REQ.wdata[7], 2)) &&
       (CTRL.step_pct == {1'b0, $past(REG_REQ.wdata[6:5], 2)} + 3'h1)))
    else $error("step select wrong");

  // a read of F6h answers with the register next cycle
  AST_EMI_READ: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.rd && emi_hit) |=> (REG_RDATA == $past(chk_emi)))
    else $error("interference read wrong");

  // a read of F7h answers with the register next cycle
  AST_OVR_READ: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.rd && ovr_hit) |=> (REG_RDATA == $past(chk_ovr)))
    else $error("overdrive read wrong");

  // a read of any other address answers zero
  AST_NONE_READ: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.rd && !emi_hit && !ovr_hit) |=> (REG_RDATA == LEOC_UNMAPPED))
    else $error("unmapped read not zero");

  // the read answer stands until the next read strobe
  AST_RDATA_HOLD: assert property (@(posedge CLK) disable iff (RST)
    !REG_REQ.rd |=> $stable(REG_RDATA))
    else $error("read answer changed without a read");

  // writes elsewhere leave both registers alone
  AST_NONE_WRITE: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.wr && !emi_hit && !ovr_hit && !NV.load) |=>
      ($stable(chk_emi) && $stable(chk_ovr)))
    else $error("unmapped write changed a register");

  // reserved bit 3 of F6h never holds a one
  AST_RESERVED_BIT_ZERO: assert property (@(posedge CLK) disable iff (RST)
    !chk_emi[3])
    else $error("reserved bit stored");

  // shadow load copies both bytes when no write competes
  AST_LOAD: assert property (@(posedge CLK) disable iff (RST)
    (NV.load && !REG_REQ.wr) |=>
      ((chk_emi == ($past(NV.emi) & LEOC_EMI_WMASK)) &&
       (chk_ovr == $past(NV.ovr))))
    else $error("shadow load not stored");

  // a write to F7h beats the load there, F6h still loads
  AST_LOAD_SPLIT: assert property (@(posedge CLK) disable iff (RST)
    (NV.load && REG_REQ.wr && ovr_hit) |=>
      (chk_emi == ($past(NV.emi) & LEOC_EMI_WMASK)))
    else $error("shadow load lost beside a write");

  // spread shape bit follows two cycles after the write
  AST_SHAPE: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.wr && emi_hit) |-> ##2
      (CTRL.spread_random == $past(REG_REQ.wdata[2], 2)))
    else $error("spread shape wrong");

  // timeout code passes out two cycles after the write
  AST_TIMEOUT: assert property (@(posedge CLK) disable iff (RST)
    (REG_REQ.wr && ovr_hit) |-> ##2
      (CTRL.ovr_timeout == $past(REG_REQ.wdata[7:4], 2)))
    else $error("timeout code wrong");

  // a high step pin reaches the settings after three edges
  AST_STEP_PIN: assert property (@(posedge CLK) disable iff (RST)
    STEP_PIN |-> ##3 CTRL.step_active)
    else $error("step pin not applied");

  // a high overdrive pin reaches the settings after three edges
  AST_OVR_PIN: assert property (@(posedge CLK) disable iff (RST)
    OVR_PIN |-> ##3 CTRL.ovr_active)
    else $error("overdrive pin not applied");

endmodule : leoc_regs

// file: leoc_regs_test.sv
// self-checking bench for the lamp configuration registers
`timescale 1ns/1ps

module leoc_regs_test;
  import leoc_pkg::*;
  // ----------
  // stimulus and counters
  // ----------
  logic clk = 1'b0; // 20 MHz clock
  logic rst = 1'b1; // async reset
  leoc_req_s req = '0; // register access
  leoc_nv_s nv = '0; // shadow load
  logic step_pin = 1'b0; // step-invoke pin
  logic ovr_pin = 1'b0; // overdrive pin
  logic [7:0] rdata; // read answer
  leoc_ctrl_s ctrl; // settings out
  int mismatches = 0; // failed compares
  int checks_done = 0; // all compares

  // clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end

  leoc_regs dut (.CLK(clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
    .NV(nv), .STEP_PIN(step_pin), .OVR_PIN(ovr_pin), .CTRL(ctrl));

  // ----------
  // shared tasks
  // ----------
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one write, returns once the settings have followed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask : wr

  // one read, answer judged a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    req.rd = 1'b0;
    chk(rdata, exp);
  endtask : rd

  // expected settings from register bytes and pin levels
  function automatic leoc_ctrl_s want(input logic [7:0] e,
      input logic [7:0] o, input logic sp, input logic op);
    leoc_ctrl_s c;
    case (e[1:0])
      2'h1: c.spread_x10 = LEOC_SPREAD_1P5;
      2'h2: c.spread_x10 = LEOC_SPREAD_3P0;
      2'h3: c.spread_x10 = LEOC_SPREAD_6P0;
      default: c.spread_x10 = LEOC_SPREAD_OFF;
    endcase
    c.spread_random = e[2];
    c.step_active = e[4] | sp;
    c.step_down = e[7];
    c.step_pct = {1'b0, e[6:5]} + 3'h1;
    c.ovr_active = o[3] | op;
    c.ovr_eighths = {1'b0, o[2:0]} + 4'h1;
    c.ovr_timeout = o[7:4];
    return c;
  endfunction : want

  // ----------
  // scenarios
  // ----------
  // reset values, then a reset in mid-run
  task automatic t_reset;
    rd(LEOC_EMI_ADDR, 8'h00);
    rd(LEOC_OVR_ADDR, 8'h00);
    chk(ctrl, want(8'h00, 8'h00, 1'b0, 1'b0));
    wr(LEOC_OVR_ADDR, 8'h5a);
    rst = 1'b1;
    @(negedge clk);
    chk(ctrl, 32'h0000_0000);
    rst = 1'b0;
    rd(LEOC_OVR_ADDR, 8'h00);
  endtask : t_reset

  // every spread and step code, reserved bit always written as zero
  task automatic t_emi;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[2:0], ~i[0], 1'b0, i[1], i[1:0]};
      wr(LEOC_EMI_ADDR, d);
      chk(ctrl, want(d, 8'h00, 1'b0, 1'b0));
      rd(LEOC_EMI_ADDR, d & 8'hf7);
    end
    wr(LEOC_EMI_ADDR, 8'h00);
  endtask : t_emi

  // every overdrive level, enable and timeout code
  task automatic t_ovr;
    logic [7:0] d;
    for (int i = 0; i < 16; i++) begin
      d = {~i[3:0], i[3], i[2:0]};
      wr(LEOC_OVR_ADDR, d);
      chk(ctrl, want(8'h00, d, 1'b0, 1'b0));
      rd(LEOC_OVR_ADDR, d);
    end
    wr(LEOC_OVR_ADDR, 8'h00);
  endtask : t_ovr

  // pins ORed into the enables after the sync delay
  task automatic t_pins;
    for (int p = 0; p < 5; p++) begin
      step_pin = p[1] & ~p[2];
      ovr_pin = p[0];
      repeat (3) @(negedge clk);
      chk(ctrl, want(8'h00, 8'h00, step_pin, ovr_pin));
    end
    ovr_pin = 1'b0;
  endtask : t_pins

  // unmapped address, shadow load, write beating a load
  task automatic t_misc;
    wr(8'hf5, 8'hff);
    rd(8'hf5, LEOC_UNMAPPED);
    rd(LEOC_EMI_ADDR, 8'h00);
    @(negedge clk);
    nv = '{load: 1'b1, emi: 8'hff, ovr: 8'ha5};
    @(negedge clk);
    nv.load = 1'b0;
    @(negedge clk);
    chk(ctrl, want(8'hf7, 8'ha5, 1'b0, 1'b0));
    rd(LEOC_EMI_ADDR, 8'hf7);
    @(negedge clk);
    nv = '{load: 1'b1, emi: 8'h00, ovr: 8'hc3};
    req = '{addr: LEOC_OVR_ADDR, wdata: 8'h3c, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    nv.load = 1'b0;
    req.wr = 1'b0;
    rd(LEOC_OVR_ADDR, 8'h3c);
    rd(LEOC_EMI_ADDR, 8'h00);
  endtask : t_misc

  // ----------
  // verdict, watchdog and main sequence
  // ----------
  task automatic report_and_stop;
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // the tests need well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_emi();
    t_ovr();
    t_pins();
    t_misc();
    report_and_stop();
  end
endmodule : leoc_regs_test
